// ### src/rsc_pkg.sv
// package: constants and types for the reset source controller
package rsc_pkg;

  // machine cycle of four clock states, c1..c4
  localparam int unsigned CLKS_PER_MC     = 4;
  localparam logic [1:0]  STATE_C4        = 2'h3;
  // external reset needs this many consecutive high samples
  localparam logic [1:0]  EXT_HIGH_SAMPLES = 2'h2;
  // reset stretch after release, in machine cycles
  localparam logic [1:0]  STRETCH_MC      = 2'h2;
  // watchdog grace after time-out, in clocks
  localparam int unsigned WDT_GRACE_CLKS  = 512;
  localparam logic [9:0]  WDT_GRACE_LAST  = 10'(WDT_GRACE_CLKS - 1);
  // watchdog reset held for two machine cycles, in clocks
  localparam logic [3:0]  WDT_HOLD_CLKS   = 4'(2 * CLKS_PER_MC);
  // watchdog divider taps, selected by two interval bits
  localparam int unsigned WDT_DIV_W       = 26;
  localparam logic [25:0] WDT_TAP_0       = 26'h001ffff;
  localparam logic [25:0] WDT_TAP_1       = 26'h007ffff;
  localparam logic [25:0] WDT_TAP_2       = 26'h01fffff;
  localparam logic [25:0] WDT_TAP_3       = 26'h3ffffff;

  // core reset vector and stack pointer start value
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam logic [7:0]  RESET_SP        = 8'h07;

  // register offsets on the plain register port
  localparam logic [3:0]  ADDR_WDCTRL     = 4'h0;
  localparam logic [3:0]  ADDR_AUX1       = 4'h1;
  localparam logic [3:0]  ADDR_TA         = 4'h2;
  localparam logic [3:0]  ADDR_CAUSE      = 4'h3;
  // watchdog_control_reg fields
  localparam int unsigned WD_RUN_BIT      = 7;
  localparam int unsigned WD_CLR_BIT      = 0;
  localparam int unsigned WD_RSTEN_BIT    = 1;
  localparam int unsigned WD_WATCHDOG_RESET_FLAG_BIT     = 2;
  localparam int unsigned WD_IF_BIT       = 3;
  localparam int unsigned WD_POR_BIT      = 6;
  localparam int unsigned WD_SEL_LSB      = 4;
  // auxiliary_control_one field
  localparam int unsigned AUX_SRST_BIT    = 3;
  // timed access unlock keys
  localparam logic [7:0]  TA_KEY1         = 8'haa;
  localparam logic [7:0]  TA_KEY2         = 8'h55;
  localparam logic [2:0]  TA_WINDOW       = 3'h4;
  localparam logic [7:0]  WDCTRL_RESET    = 8'h00;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rsc_bus_t;

  // reset cause snapshot
  typedef struct packed {
    logic ext;
    logic por;
    logic bor;
    logic wdt;
    logic sw;
  } rsc_cause_t;

  // watchdog divider tap for a two bit selection
  function automatic logic [25:0] rsc_tap(input logic [1:0] sel);
    case (sel)
      2'h0:    rsc_tap = WDT_TAP_0;
      2'h1:    rsc_tap = WDT_TAP_1;
      2'h2:    rsc_tap = WDT_TAP_2;
      default: rsc_tap = WDT_TAP_3;
    endcase
  endfunction

endpackage

// ### src/rsc_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module rsc_sync
  import rsc_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  // clocking
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         clk_en,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else if (clk_en)
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // rsc_sync

// ### src/rsc_top.sv
// reset source controller: external, power-on, brown-out, watchdog, soft
//
// Behaviour
// RQ1: sample reset pin at state c4 only
// RQ2: two consecutive high samples assert reset
// RQ3: recognition purely synchronous, needs running clock
// RQ4: hold reset two cycles after release, vector 0000h
// RQ5: external reset sets no cause flag
// RQ6: supply rise performs reset, sets power-on flag
// RQ7: software should clear power-on flag
// RQ8: hold reset during brown-out, then reset
// RQ9: software clears watchdog before time-out
// RQ10: time-out sets watchdog flag regardless of enable
// RQ11: reset 512 clocks after time-out if enabled
// RQ12: watchdog reset two cycles, sets reset flag
// RQ13: resume fetch at 0000h after watchdog reset
// RQ14: only cause flags depend on reset source
// RQ15: timed-access write of soft bit resets system
// RQ16: load pc zero, sp 07h; power-on disables watchdog
// RQ17: internal reset ORs all qualified synchronous requests
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
(
  // clocking
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // board and supply monitor
  input  wire logic       reset_pin,
  input  wire logic       supply_ok,
  input  wire logic       brownout_low,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // core side
  output logic            core_reset,
  output logic     [15:0] core_pc_load,
  output logic      [7:0] core_sp_load,
  output logic            watchdog_irq_flag,
  output logic      [1:0] clock_state
);

  typedef enum logic [3:0] {
    ST_RUN     = 4'b0001,
    ST_HOLD    = 4'b0010,
    ST_STRETCH = 4'b0100,
    ST_BOOT    = 4'b1000
  } rsc_state_t;

  rsc_bus_t   bus;
  rsc_cause_t req;
  rsc_state_t state;
  logic [2:0] pins_s;
  logic       pin_s, ok_s, low_s;
  logic [1:0] phase;
  logic [1:0] high_cnt;
  logic       ext_req;
  logic       ok_d;
  logic       por_pend;
  logic       por_req;
  logic [1:0] mc_cnt;
  logic       c4;
  logic       any_req;
  // watchdog
  logic [25:0] wdt_div;
  logic        wdt_run;
  logic        wdt_rsten;
  logic [1:0]  wdt_sel;
  logic        wdt_if;
  logic        wdt_rf;
  logic        por_flag;
  logic        grace;
  logic [9:0]  grace_cnt;
  logic [3:0]  wdt_hold;
  logic        wdt_clr;
  logic        wdt_timeout;
  logic        wdt_fire;
  // timed access and soft reset
  logic [1:0]  ta_stage;
  logic [2:0]  ta_win;
  logic        ta_open;
  logic        sw_req;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // all pin-side levels pass two flops before use
  rsc_sync #(.W(3)) u_sync
  (
    .clock  (clock),
    .rst    (rst),
    .clk_en (clk_en),
    .d      ({reset_pin, supply_ok, brownout_low}),
    .q      (pins_s)
  );
  assign pin_s = pins_s[2];
  assign ok_s  = pins_s[1];
  assign low_s = pins_s[0];

  // clock state counter c1..c4, free running
  always_ff @(posedge clock)
  begin
    if (rst)
      phase <= 2'h0;
    else if (clk_en)
      phase <= phase + 2'h1;
  end
  assign c4 = (phase == STATE_C4);
  assign clock_state = phase;

  // pin only looked at in c4; no async path exists [RQ1] [RQ3]
  always_ff @(posedge clock)
  begin
    if (rst)
      high_cnt <= 2'h0;
    else if (clk_en && c4)
    begin
      if (!pin_s)
        high_cnt <= 2'h0;
      else if (high_cnt != EXT_HIGH_SAMPLES)
        high_cnt <= high_cnt + 2'h1; // saturates at two
    end
  end
  assign ext_req = (high_cnt == EXT_HIGH_SAMPLES); // [RQ2]

  // supply rise edge makes a power-on request until a c4 seen in ST_HOLD
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ok_d     <= 1'b0;
      por_pend <= 1'b0;
    end
    else if (clk_en)
    begin
      ok_d <= ok_s;
      if (ok_s && !ok_d)
        por_pend <= 1'b1; // [RQ6]
      else if (state == ST_HOLD && c4)
        por_pend <= 1'b0;
    end
  end
  assign por_req = por_pend;

  // watchdog divider, restart on clear or reset
  always_ff @(posedge clock)
  begin
    if (rst || (clk_en && state != ST_RUN)) // frozen while clk_en low
      wdt_div <= '0;
    else if (clk_en)
    begin
      if (wdt_clr || !wdt_run)
        wdt_div <= '0; // [RQ9]
      else if (wdt_timeout)
        wdt_div <= '0;
      else
        wdt_div <= wdt_div + 26'h1;
    end
  end
  assign wdt_timeout = wdt_run && (wdt_div == rsc_tap(wdt_sel));

  // 512 clock grace window after each time-out
  always_ff @(posedge clock)
  begin
    if (rst || (clk_en && state != ST_RUN))
    begin
      grace     <= 1'b0;
      grace_cnt <= 10'h0;
    end
    else if (clk_en)
    begin
      if (wdt_clr)
        grace <= 1'b0; // clear cancels the pending reset
      else if (wdt_timeout && !grace)
      begin
        grace     <= 1'b1;
        grace_cnt <= 10'h0;
      end
      else if (grace)
      begin
        grace_cnt <= grace_cnt + 10'h1;
        if (grace_cnt == WDT_GRACE_LAST)
          grace <= 1'b0;
      end
    end
  end
  // exactly 512 clocks after time-out, only if enabled [RQ11]
  assign wdt_fire = grace && !wdt_clr && wdt_rsten &&
                    (grace_cnt == WDT_GRACE_LAST);

  // timed access: key1 then key2 opens a short write window
  always_ff @(posedge clock)
  begin
    if (rst || (clk_en && state != ST_RUN))
    begin
      ta_stage <= 2'h0;
      ta_win   <= 3'h0;
    end
    else if (clk_en)
    begin
      if (bus.wr && bus.addr == ADDR_TA)
      begin
        if (bus.wdata == TA_KEY1)
          ta_stage <= 2'h1;
        else if (bus.wdata == TA_KEY2 && ta_stage == 2'h1)
        begin
          ta_stage <= 2'h2;
          ta_win   <= TA_WINDOW;
        end
        else
          ta_stage <= 2'h0;
      end
      else if (ta_win != 3'h0)
        ta_win <= ta_win - 3'h1;
      else
        ta_stage <= 2'h0;
    end
  end
  assign ta_open = (ta_stage == 2'h2) && (ta_win != 3'h0);
  assign sw_req  = ta_open && bus.wr && bus.addr == ADDR_AUX1 &&
                   bus.wdata[AUX_SRST_BIT]; // [RQ15]

  assign wdt_clr = bus.wr && bus.addr == ADDR_WDCTRL &&
                   bus.wdata[WD_CLR_BIT] && state == ST_RUN;
  assign req = '{ext: ext_req, por: por_req, bor: low_s,
                 wdt: wdt_fire, sw: sw_req};
  assign any_req = |req; // [RQ17]

  // reset sequencer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state    <= ST_BOOT;
      mc_cnt   <= 2'h0;
      wdt_hold <= 4'h0;
    end
    else if (clk_en)
    begin
      case (state)
        ST_BOOT:
          state <= ST_HOLD;
        ST_RUN:
          if (wdt_fire)
          begin
            state    <= ST_HOLD;
            wdt_hold <= WDT_HOLD_CLKS; // two machine cycles [RQ12]
          end
          else if (any_req)
            state <= ST_HOLD;
        ST_HOLD:
        begin
          if (wdt_hold != 4'h0)
            wdt_hold <= wdt_hold - 4'h1;
          // held while pin high or supply low [RQ8]
          if (!ext_req && !low_s && !por_pend && wdt_hold <= 4'h1)
          begin
            state  <= ST_STRETCH;
            mc_cnt <= 2'h0;
          end
        end
        ST_STRETCH:
          if (ext_req || low_s || por_pend)
            state <= ST_HOLD;
          else if (c4)
          begin
            // release after up to two machine cycles [RQ4]
            mc_cnt <= mc_cnt + 2'h1;
            if (mc_cnt + 2'h1 == STRETCH_MC)
              state <= ST_RUN;
          end
        default:
          state <= ST_HOLD;
      endcase
    end
  end

  // core reset and start vector from flops [RQ4] [RQ13] [RQ16]
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_reset   <= 1'b1;
      core_pc_load <= RESET_VECTOR;
      core_sp_load <= RESET_SP;
    end
    else if (clk_en)
    begin
      core_reset   <= (state != ST_RUN) || (any_req && state == ST_RUN);
      core_pc_load <= RESET_VECTOR;
      core_sp_load <= RESET_SP;
    end
  end

  // watchdog control and cause flags; set beats clear [RQ14]
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wdt_run   <= 1'b0;
      wdt_rsten <= 1'b0;
      wdt_sel   <= 2'h0;
      wdt_if    <= 1'b0;
      wdt_rf    <= 1'b0;
      por_flag  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == ST_HOLD)
      begin
        // common reset values, whatever the source
        wdt_rsten <= 1'b0;
        wdt_sel   <= 2'h0;
        wdt_if    <= 1'b0;
        if (por_pend)
        begin
          wdt_run  <= 1'b0; // power-on disables watchdog [RQ16]
          por_flag <= 1'b1; // [RQ6]
          wdt_rf   <= 1'b0;
        end
        // no flag for external or brown-out [RQ5]
      end
      else
      begin
        if (bus.wr && bus.addr == ADDR_WDCTRL)
        begin
          wdt_run   <= bus.wdata[WD_RUN_BIT];
          wdt_rsten <= bus.wdata[WD_RSTEN_BIT];
          wdt_sel   <= bus.wdata[WD_SEL_LSB +: 2];
          if (!bus.wdata[WD_IF_BIT])
            wdt_if <= 1'b0;
          if (!bus.wdata[WD_WATCHDOG_RESET_FLAG_BIT])
            wdt_rf <= 1'b0;
          if (!bus.wdata[WD_POR_BIT])
            por_flag <= 1'b0; // software clear [RQ7]
        end
        if (wdt_timeout)
          wdt_if <= 1'b1; // set even with reset disabled [RQ10]
        if (wdt_fire)
          wdt_rf <= 1'b1; // [RQ12]
      end
    end
  end
  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata         <= 8'h00;
      watchdog_irq_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      watchdog_irq_flag <= wdt_if;
      reg_rdata         <= 8'h00;
      if (bus.rd)
        case (bus.addr)
          ADDR_WDCTRL:
            reg_rdata <= {wdt_run, por_flag, wdt_sel, wdt_if,
                          wdt_rf, wdt_rsten, 1'b0};
          ADDR_AUX1:
            reg_rdata <= 8'h00; // soft reset bit self clears
          ADDR_TA:
            reg_rdata <= {6'h00, ta_stage};
          ADDR_CAUSE:
            reg_rdata <= {3'h0, req};
          default:
            reg_rdata <= 8'h00;
        endcase
    end
  end

endmodule // rsc_top

// ### sim/rsc_top_sva.sv
// checker: port-level properties of the reset source controller
`timescale 1ns/1ps
module rsc_top_sva
  import rsc_pkg::*;
(
  // clocking
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clk_en,
  // board and supply
  input wire logic        reset_pin,
  input wire logic        supply_ok,
  input wire logic        brownout_low,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // core side
  input wire logic        core_reset,
  input wire logic [15:0] core_pc_load,
  input wire logic [7:0]  core_sp_load,
  input wire logic        watchdog_irq_flag,
  input wire logic [1:0]  clock_state
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_PC_ZERO:
    assert property (core_pc_load == 16'h0000) else $error("pc load not zero");
  AST_SP_SEVEN:
    assert property (core_sp_load == 8'h07) else $error("sp load not 07");
  AST_PHASE_STEP:
    assert property (clk_en && !rst |=>
                     clock_state == 2'($past(clock_state) + 2'h1))
    else $error("clock state did not advance");
  AST_EXT_HELD:
    assert property (reset_pin [*8] ##1 reset_pin [*8] |-> core_reset)
    else $error("held reset pin not honoured");
  AST_BROWNOUT:
    assert property (brownout_low [*6] |-> core_reset)
    else $error("brown-out did not hold reset");
  AST_SUPPLY_RISE:
    assert property ($rose(supply_ok) |-> ##[1:6] core_reset)
    else $error("supply rise did not reset");
  AST_MIN_HOLD:
    assert property ($rose(core_reset) |-> core_reset [*5])
    else $error("reset pulse too short");
  AST_UNMAPPED:
    assert property (reg_rd && reg_addr > ADDR_CAUSE |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // main scenarios reached
  cover property ($rose(core_reset));
  cover property (brownout_low [*6]);
  cover property (reg_rd && reg_addr == ADDR_WDCTRL);
endmodule // rsc_top_sva

bind rsc_top rsc_top_sva rsc_top_sva_inst (
  .clock(clock), .rst(rst), .clk_en(clk_en), .reset_pin(reset_pin),
  .supply_ok(supply_ok), .brownout_low(brownout_low),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset(core_reset),
  .core_pc_load(core_pc_load), .core_sp_load(core_sp_load),
  .watchdog_irq_flag(watchdog_irq_flag), .clock_state(clock_state));

// ### sim/rsc_far_model.sv
// far side model: board reset driver and supply comparators
`timescale 1ns/1ps
module rsc_far_model
(
  // clocking
  input  wire logic clock,
  // requests from the bench
  input  wire logic pin_req,
  input  wire logic pwr_req,
  input  wire logic sag_req,
  // board and supply lines
  output logic      reset_pin = 1'b0,
  output logic      supply_ok = 1'b0,
  output logic      brownout_low = 1'b0
);
  // lines move one clock after the request; the device syncs them anyway
  always @(posedge clock)
  begin
    reset_pin    <= pin_req;
    supply_ok    <= pwr_req;
    brownout_low <= sag_req;
  end
endmodule // rsc_far_model

// ### sim/rsc_top_tb_top.sv
// testbench: pin, supply and brown-out resets driven through the far side model, soft reset through the register port
`timescale 1ns/1ps
module rsc_top_tb_top;
  import rsc_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        pin_req = 1'b0;
  logic        pwr_req = 1'b0;
  logic        sag_req = 1'b0;
  logic        reset_pin, supply_ok, brownout_low;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, core_sp_load, rd_val;
  logic [15:0] core_pc_load;
  logic        core_reset;
  logic        wdt_irq;
  logic [1:0]  clock_state;
  int          n_mismatch = 0;
  int          checks = 0;

  // watchdog taps are 2^17 clocks or more, too long for this run
  always #12.5 clock = ~clock;

  rsc_far_model rsc_far_model_inst (.clock(clock), .pin_req(pin_req),
    .pwr_req(pwr_req), .sag_req(sag_req), .reset_pin(reset_pin),
    .supply_ok(supply_ok), .brownout_low(brownout_low));
  rsc_top rsc_top_inst (.clock(clock), .rst(rst), .clk_en(1'b1),
    .reset_pin(reset_pin), .supply_ok(supply_ok),
    .brownout_low(brownout_low), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_reset(core_reset),
    .core_pc_load(core_pc_load), .core_sp_load(core_sp_load),
    .watchdog_irq_flag(wdt_irq), .clock_state(clock_state));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait; running out is a mismatch and ends the run
  task automatic wait_core(input logic lvl, input int bound);
    int i;
    i = 0;
    while (core_reset !== lvl && i < bound)
    begin
      @(posedge clock);
      #1;
      i++;
    end
    chk("core_reset", {15'h0, lvl}, {15'h0, core_reset});
    if (core_reset !== lvl)
      final_report();
  endtask

  task automatic hold_chk(input logic lvl, input int n);
    repeat (n)
    begin
      @(posedge clock);
      #1;
      chk("core_reset", {15'h0, lvl}, {15'h0, core_reset});
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  // data stand only in the cycle after the read edge
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  task automatic t_power();
    @(posedge clock);
    pwr_req <= 1'b1;
    wait_core(1'b0, 200);
    chk("pc", 16'h0000, core_pc_load);
    chk("sp", 16'h0007, {8'h00, core_sp_load});
    chk("irq", 16'h0000, {15'h0, wdt_irq});
    rd_chk(ADDR_WDCTRL, 8'h40);
    wr(ADDR_WDCTRL, 8'h00);
    rd_chk(ADDR_WDCTRL, 8'h00);
    wr(ADDR_WDCTRL, 8'h01);
    rd_chk(ADDR_WDCTRL, 8'h00);
    rd_chk(4'hf, 8'h00);
    $display("power-on test done");
  endtask

  // one machine cycle high gives one sample only: no reset
  task automatic t_ext_short();
    @(posedge clock);
    pin_req <= 1'b1;
    repeat (4) @(posedge clock);
    pin_req <= 1'b0;
    hold_chk(1'b0, 24);
    $display("short pin test done");
  endtask

  task automatic t_ext();
    @(posedge clock);
    pin_req <= 1'b1;
    repeat (20) @(posedge clock);
    #1;
    chk("core_reset", 16'h0001, {15'h0, core_reset});
    @(posedge clock);
    pin_req <= 1'b0;
    hold_chk(1'b1, 3);
    wait_core(1'b0, 16);
    rd_chk(ADDR_WDCTRL, 8'h00);
    $display("external reset test done");
  endtask

  task automatic t_brown();
    @(posedge clock);
    sag_req <= 1'b1;
    wait_core(1'b1, 8);
    hold_chk(1'b1, 40);
    @(posedge clock);
    sag_req <= 1'b0;
    wait_core(1'b0, 30);
    rd_chk(ADDR_WDCTRL, 8'h00);
    $display("brown-out test done");
  endtask

  // locked write must be ignored, unlocked one resets
  task automatic t_soft();
    wr(ADDR_AUX1, 8'h08);
    hold_chk(1'b0, 8);
    // keys on back-to-back edges, strobe held high between them
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_TA;
    reg_wdata <= TA_KEY1;
    @(posedge clock);
    reg_wdata <= TA_KEY2;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
    wr(ADDR_AUX1, 8'h08);
    wait_core(1'b1, 8);
    wait_core(1'b0, 40);
    rd_chk(ADDR_AUX1, 8'h00);
    $display("soft reset test done");
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_power();
    t_ext_short();
    t_ext();
    t_brown();
    t_soft();
    final_report();
  end
endmodule // rsc_top_tb_top
